// File: ccm_pkg.sv
// Package for the cache maintenance and monitor control block.
package ccm_pkg;

  localparam int unsigned AW = 32;
  localparam int unsigned DW = 32;

  // Register byte addresses.
  localparam logic [31:0] OFF_TYPE      = 32'h4007c000;
  localparam logic [31:0] OFF_GATING    = 32'h4007c004;
  localparam logic [31:0] OFF_CONTROL   = 32'h4007c008;
  localparam logic [31:0] OFF_STATE     = 32'h4007c00c;
  localparam logic [31:0] OFF_FLUSH     = 32'h4007c020;
  localparam logic [31:0] OFF_LINEINV   = 32'h4007c024;
  localparam logic [31:0] OFF_MONSEL    = 32'h4007c028;
  localparam logic [31:0] OFF_MONGATE   = 32'h4007c02c;
  localparam logic [31:0] OFF_MONCMD    = 32'h4007c030;
  localparam logic [31:0] OFF_MONCOUNT  = 32'h4007c034;

  // Field positions.
  localparam int unsigned POS_CAPACITY  = 0;
  localparam int unsigned POS_LINELEN   = 4;
  localparam int unsigned POS_GATINGOFF = 0;
  localparam int unsigned POS_CACHEON   = 0;
  localparam int unsigned POS_FLUSHALL  = 0;
  localparam int unsigned POS_INDEX     = 4;
  localparam int unsigned POS_WAY       = 30;
  localparam int unsigned POS_MODE      = 0;
  localparam int unsigned POS_MONON     = 0;
  localparam int unsigned POS_CLEAR     = 0;

  // Structure of the cache: fixed at 2 KB, 16-byte lines, 4 ways.
  localparam logic [1:0]  CAPACITY_CODE = 2'h1;
  localparam logic [1:0]  LINELEN_CODE  = 2'h2;
  localparam int unsigned NUM_WAYS      = 4;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned NUM_SETS      = 32;

  // Reset values.
  localparam logic        RST_GATINGOFF = 1'b0;
  localparam logic        RST_CACHEON   = 1'b0;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic        RST_MONON     = 1'b0;
  localparam logic [31:0] RST_COUNT     = 32'h00000000;

  typedef enum logic [1:0] {
    CCM_MODE_CYCLE = 2'b00,
    CCM_MODE_IHIT  = 2'b01,
    CCM_MODE_DHIT  = 2'b10
  } ccm_mode_t;

  typedef enum logic [1:0] {
    CCM_ST_IDLE  = 2'b00,
    CCM_ST_FLUSH = 2'b01
  } ccm_state_t;

  // Register port request.
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } ccm_req_t;

  // Lookup from the cache datapath.
  typedef struct packed {
    logic             valid;
    logic             isData;
    logic [IDX_W-1:0] index;
    logic [1:0]       way;
    logic             tagMatch;
  } ccm_lookup_t;

endpackage

// File: ccm_ctrl.sv
// Register control, line validity and hit monitor of the embedded cache controller.
// Function
// - The type register reports capacity with a 2-bit code, 0..3 meaning 1, 2, 4, 8 KB.
// - The type register reports line length with a 2-bit code, 0..3 meaning 4..32 bytes.
// - Cache clock is gated dynamically while gating_off is 0 and runs free while it is 1.
// - Writing the control register sets the cache on with 1 and off with 0.
// - The state register reads 1 while the cache is on and 0 while off.
// - Writing 1 to flush_all invalidates every entry; writing 0 does nothing.
// - A write to line_invalidate_cmd invalidates the line at the given index and way.
// - The index field width follows capacity: 5, 6 or 7 bits for 2, 4 or 8 KB.
// - The way field is a 2-bit code that picks way 0 to way 3.
// - The monitor counts cycles, instruction hits or data hits for mode 0, 1 or 2.
// - The monitor counts only while monitor_on is 1 and holds while it is 0.
// - Writing 1 to counter_clear resets the 32-bit tally; writing 0 does nothing.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module ccm_ctrl
  import ccm_pkg::*;
(
  input  wire logic                core_clk,    // System clock, 100 MHz.
  input  wire logic                nrst,        // Asynchronous reset, active low.
  input  wire ccm_pkg::ccm_req_t   regReq,      // Register port request.
  output logic [ccm_pkg::DW-1:0]   regRdata,    // Read data, one cycle after the read.
  input  wire ccm_pkg::ccm_lookup_t lookup,     // Lookup from the datapath.
  input  wire logic                fillValid,   // Datapath fills a line.
  input  wire logic [ccm_pkg::IDX_W-1:0] fillIndex, // Index of the filled line.
  input  wire logic [1:0]          fillWay,     // Way of the filled line.
  output logic                     lookupHit,   // Registered hit answer for the lookup.
  output logic                     cacheOn,     // Cache controller enabled.
  output logic                     clkGateEn,   // High lets the cache clock gate dynamically.
  output logic                     busy         // Flush in progress; lookups miss.
);
  import ccm_pkg::*;

  logic [NUM_WAYS-1:0][NUM_SETS-1:0] lineValid_q;
  logic       gatingOff_q;
  logic       cacheOn_q;
  logic [1:0] mode_q;
  logic       monOn_q;
  logic [31:0] tally_q;
  logic [31:0] tally_d;
  ccm_state_t state_q;
  logic [IDX_W-1:0] flushIdx_q;
  logic [DW-1:0] rdata_q;
  logic       hit_q;
  logic       clkGate_q;
  logic       busy_q;

  logic wrGating, wrControl, wrFlush, wrLineInv, wrMonSel, wrMonGate, wrMonCmd;
  logic flushReq;
  logic [IDX_W-1:0] invIdx;
  logic [1:0]       invWay;
  logic             countEvent;
  logic             hitNow;

  function automatic logic isAddr(input logic [AW-1:0] a, input logic [31:0] off);
    isAddr = (a == off);
  endfunction

  assign wrGating  = regReq.wr && isAddr(regReq.addr, OFF_GATING);
  assign wrControl = regReq.wr && isAddr(regReq.addr, OFF_CONTROL);
  assign wrFlush   = regReq.wr && isAddr(regReq.addr, OFF_FLUSH);
  assign wrLineInv = regReq.wr && isAddr(regReq.addr, OFF_LINEINV);
  assign wrMonSel  = regReq.wr && isAddr(regReq.addr, OFF_MONSEL);
  assign wrMonGate = regReq.wr && isAddr(regReq.addr, OFF_MONGATE);
  assign wrMonCmd  = regReq.wr && isAddr(regReq.addr, OFF_MONCMD);

  assign flushReq = wrFlush && regReq.wdata[POS_FLUSHALL];
  // Bits of the index above the fixed 2 KB width are ignored.
  assign invIdx   = regReq.wdata[POS_INDEX +: IDX_W];
  assign invWay   = regReq.wdata[POS_WAY +: 2];

  // Configuration registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gatingOff_q <= RST_GATINGOFF;
      cacheOn_q   <= RST_CACHEON;
      mode_q      <= RST_MODE;
      monOn_q     <= RST_MONON;
    end else begin
      if (wrGating) begin
        gatingOff_q <= regReq.wdata[POS_GATINGOFF];
      end
      if (wrControl) begin
        cacheOn_q <= regReq.wdata[POS_CACHEON];
      end
      if (wrMonSel) begin
        mode_q <= regReq.wdata[POS_MODE +: 2];
      end
      if (wrMonGate) begin
        monOn_q <= regReq.wdata[POS_MONON];
      end
    end
  end

  // Clock gate enable: gating is allowed only while the cache is idle and not disabled.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clkGate_q <= 1'b0;
    end else begin
      clkGate_q <= !gatingOff_q && !lookup.valid && !fillValid && (state_q == CCM_ST_IDLE);
    end
  end

  // Flush walks one set per cycle; every way of that set is cleared at once.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= CCM_ST_IDLE;
      flushIdx_q <= '0;
    end else begin
      case (state_q)
        CCM_ST_IDLE: begin
          if (flushReq) begin
            state_q    <= CCM_ST_FLUSH;
            flushIdx_q <= '0;
          end
        end
        CCM_ST_FLUSH: begin
          flushIdx_q <= flushIdx_q + 1'b1;
          if (flushIdx_q == IDX_W'(NUM_SETS - 1)) begin
            state_q <= CCM_ST_IDLE;
          end
        end
        default: state_q <= CCM_ST_IDLE;
      endcase
    end
  end

  // Busy is kept in its own flop so the output carries no decode glitch; it tracks the walk exactly.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
    end else if (state_q == CCM_ST_IDLE) begin
      busy_q <= flushReq;
    end else if (flushIdx_q == IDX_W'(NUM_SETS - 1)) begin
      busy_q <= 1'b0;
    end
  end

  // Valid bits. Invalidation wins over a fill of the same line in the same cycle.
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WAYS; gw++) begin : gWay
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          lineValid_q[gw] <= '0;
        end else if (flushReq) begin
          lineValid_q[gw] <= '0;
        end else begin
          if (fillValid && fillWay == 2'(gw) && state_q == CCM_ST_IDLE) begin
            lineValid_q[gw][fillIndex] <= 1'b1;
          end
          if (state_q == CCM_ST_FLUSH) begin
            lineValid_q[gw][flushIdx_q] <= 1'b0;
          end
          if (wrLineInv && invWay == 2'(gw)) begin
            lineValid_q[gw][invIdx] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // A lookup in the same cycle as an invalidate of its line is forced to miss.
  always_comb begin
    hitNow = lookup.valid && cacheOn_q && lookup.tagMatch && (state_q == CCM_ST_IDLE)
             && !flushReq && lineValid_q[lookup.way][lookup.index]
             && !(wrLineInv && invWay == lookup.way && invIdx == lookup.index);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hitNow;
    end
  end

  always_comb begin
    case (mode_q)
      CCM_MODE_CYCLE: countEvent = 1'b1;
      CCM_MODE_IHIT:  countEvent = hitNow && !lookup.isData;
      CCM_MODE_DHIT:  countEvent = hitNow && lookup.isData;
      default:        countEvent = 1'b0;
    endcase
  end

  // Clear wins over a same-cycle event so that software sees exactly zero.
  always_comb begin
    tally_d = tally_q;
    if (wrMonCmd && regReq.wdata[POS_CLEAR]) begin
      tally_d = RST_COUNT;
    end else if (monOn_q && countEvent) begin
      tally_d = tally_q + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tally_q <= RST_COUNT;
    end else begin
      tally_q <= tally_d;
    end
  end

  // Read data; write-only and unmapped addresses read as zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (regReq.rd) begin
      rdata_q <= '0;
      if (isAddr(regReq.addr, OFF_TYPE)) begin
        rdata_q[POS_CAPACITY +: 2] <= CAPACITY_CODE;
        rdata_q[POS_LINELEN +: 2]  <= LINELEN_CODE;
      end else if (isAddr(regReq.addr, OFF_GATING)) begin
        rdata_q[POS_GATINGOFF] <= gatingOff_q;
      end else if (isAddr(regReq.addr, OFF_STATE)) begin
        rdata_q[POS_CACHEON] <= cacheOn_q;
      end else if (isAddr(regReq.addr, OFF_MONSEL)) begin
        rdata_q[POS_MODE +: 2] <= mode_q;
      end else if (isAddr(regReq.addr, OFF_MONGATE)) begin
        rdata_q[POS_MONON] <= monOn_q;
      end else if (isAddr(regReq.addr, OFF_MONCOUNT)) begin
        rdata_q <= tally_q;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign regRdata  = rdata_q;
  assign lookupHit = hit_q;
  assign cacheOn   = cacheOn_q;
  assign clkGateEn = clkGate_q;
  assign busy      = busy_q;

endmodule

// File: ccm_ctrl_props.sv
// Assertions on the ports of the cache control block.
`timescale 1ns/10ps
module ccm_ctrl_props
  import ccm_pkg::*;
(
  core_clk,  // Clock.
  nrst,      // Reset, active low.
  regReq,    // Register request.
  regRdata,  // Read data.
  lookup,    // Datapath lookup.
  fillValid, // Fill strobe.
  fillIndex, // Fill index.
  fillWay,   // Fill way.
  lookupHit, // Hit answer.
  cacheOn,   // Cache enabled.
  clkGateEn, // Gating allowed.
  busy       // Flush walk.
);
  input wire logic                      core_clk;
  input wire logic                      nrst;
  input wire ccm_pkg::ccm_req_t         regReq;
  input wire logic [ccm_pkg::DW-1:0]    regRdata;
  input wire ccm_pkg::ccm_lookup_t      lookup;
  input wire logic                      fillValid;
  input wire logic [ccm_pkg::IDX_W-1:0] fillIndex;
  input wire logic [1:0]                fillWay;
  input wire logic                      lookupHit;
  input wire logic                      cacheOn;
  input wire logic                      clkGateEn;
  input wire logic                      busy;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic [1:0] modeQ;
  logic       monOnQ;
  wire        monRd = regReq.rd && regReq.addr == OFF_MONCOUNT;
  // A shadow of the monitor settings tells what the tally should do.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modeQ <= RST_MODE;
      monOnQ <= RST_MONON;
    end else if (regReq.wr && regReq.addr == OFF_MONSEL) begin
      modeQ <= regReq.wdata[1:0];
    end else if (regReq.wr && regReq.addr == OFF_MONGATE) begin
      monOnQ <= regReq.wdata[0];
    end
  end
  AST_GATE: assert property (regReq.wr && regReq.addr == OFF_GATING && regReq.wdata[0]
    |=> ##1 !clkGateEn) else $error("gate enable wrong");
  AST_ON: assert property (regReq.wr && regReq.addr == OFF_CONTROL
    |=> cacheOn == $past(regReq.wdata[0])) else $error("cache enable wrong");
  AST_FLUSH: assert property (regReq.wr && regReq.addr == OFF_FLUSH && regReq.wdata[0]
    |=> busy[*8] ##[1:40] !busy) else $error("flush walk wrong");
  AST_NOHIT: assert property (busy |=> !lookupHit) else $error("hit during flush");
  AST_LINE: assert property (regReq.wr && regReq.addr == OFF_LINEINV
    ##1 !fillValid ##1 lookup.valid && lookup.index == $past(regReq.wdata[8:4], 2)
    && lookup.way == $past(regReq.wdata[31:30], 2) |=> !lookupHit) else $error("line hits");
  AST_CYC: assert property (monRd && monOnQ && modeQ == 2'h0 ##1 !regReq.wr ##1 monRd
    |=> regRdata == $past(regRdata, 2) + 32'h2) else $error("cycle tally wrong");
  AST_HOLD: assert property (monRd && !monOnQ ##1 !regReq.wr ##1 monRd
    |=> regRdata == $past(regRdata, 2)) else $error("tally moved while off");
  AST_CLR: assert property (regReq.wr && regReq.addr == OFF_MONCMD && regReq.wdata[0]
    ##1 !lookup.valid ##1 monRd && modeQ != 2'h0 |=> regRdata == 32'h0) else $error("clear failed");
endmodule
bind ccm_ctrl ccm_ctrl_props u_ccm_ctrl_props (.core_clk(core_clk), .nrst(nrst),
  .regReq(regReq), .regRdata(regRdata), .lookup(lookup), .fillValid(fillValid),
  .fillIndex(fillIndex), .fillWay(fillWay), .lookupHit(lookupHit), .cacheOn(cacheOn),
  .clkGateEn(clkGateEn), .busy(busy));

// File: ccm_dp_model.sv
// Datapath model that issues lookups and line fills.
`timescale 1ns/10ps
module ccm_dp_model
  import ccm_pkg::*;
(
  input  wire logic                 core_clk,  // Clock.
  output ccm_pkg::ccm_lookup_t      lookup,    // Lookup request.
  output logic                      fillValid, // Fill strobe.
  output logic [ccm_pkg::IDX_W-1:0] fillIndex, // Fill index.
  output logic [1:0]                fillWay    // Fill way.
);
  initial begin
    lookup = '0;
    fillValid = 1'b0;
    {fillIndex, fillWay} = '0;
  end
  // Idle fields are inverted so no stale value can pass for a live one.
  task look(input logic d, input logic [4:0] i, input logic [1:0] w, input logic t);
    @(posedge core_clk);
    lookup <= '{1'b1, d, i, w, t};
    @(posedge core_clk);
    lookup <= '{1'b0, ~d, ~i, ~w, ~t};
  endtask
  task fill(input logic [4:0] i, input logic [1:0] w);
    @(posedge core_clk);
    {fillValid, fillIndex, fillWay} <= {1'b1, i, w};
    @(posedge core_clk);
    {fillValid, fillIndex, fillWay} <= {1'b0, ~i, ~w};
  endtask
endmodule

// File: testbench.sv
// Self-checking testbench for the cache control block.
`timescale 1ns/10ps
module testbench;
  import ccm_pkg::*;
  logic          core_clk;
  logic          nrst;
  ccm_req_t      regReq;
  logic [31:0]   regRdata;
  ccm_lookup_t   lookup;
  logic          fillValid;
  logic [4:0]    fillIndex;
  logic [1:0]    fillWay;
  logic          lookupHit;
  logic          cacheOn;
  logic          clkGateEn;
  logic          busy;
  int            failures;
  int            total_checks;
  logic [31:0]   rdv;
  logic [31:0]   prev;
  ccm_ctrl u_ccm_ctrl (.core_clk(core_clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
    .lookup(lookup), .fillValid(fillValid), .fillIndex(fillIndex), .fillWay(fillWay),
    .lookupHit(lookupHit), .cacheOn(cacheOn), .clkGateEn(clkGateEn), .busy(busy));
  ccm_dp_model u_ccm_dp_model (.core_clk(core_clk), .lookup(lookup), .fillValid(fillValid),
    .fillIndex(fillIndex), .fillWay(fillWay));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {regReq.wr, regReq.addr, regReq.wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge core_clk);
    {regReq.rd, regReq.addr} <= {1'b1, a};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic lk(input logic d, input logic [4:0] i, input logic [1:0] w, input logic t,
    input logic e);
    u_ccm_dp_model.look(d, i, w, t);
    #1 chk("hit", 32'(e), 32'(lookupHit));
  endtask
  task automatic final_report();
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    final_report();
  end
  initial begin
    {regReq, nrst, failures, total_checks} = '0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(OFF_TYPE);
    chk("capacity", 32'(CAPACITY_CODE), 32'(rdv[1:0]));
    chk("line length", 32'(LINELEN_CODE), 32'(rdv[5:4]));
    wr(OFF_GATING, 32'h1);
    @(posedge core_clk);
    #1 chk("gating", 32'h0, 32'(clkGateEn));
    wr(OFF_GATING, 32'h0);
    @(posedge core_clk);
    #1 chk("gating", 32'h1, 32'(clkGateEn));
    wr(OFF_CONTROL, 32'h0);
    chk("cache on", 32'h0, 32'(cacheOn));
    rd(OFF_STATE);
    chk("state", 32'h0, rdv);
    wr(OFF_CONTROL, 32'h1);
    chk("cache on", 32'h1, 32'(cacheOn));
    rd(OFF_STATE);
    chk("state", 32'h1, rdv);
    rd(32'h4007c010);
    chk("unmapped", 32'h0, rdv);
    for (int w = 0; w < 4; w++) u_ccm_dp_model.fill(5'h1f, 2'(w));
    for (int w = 0; w < 4; w++) begin
      wr(OFF_LINEINV, {2'(w), 21'h0, 5'h1f, 4'h0});
      lk(1'b0, 5'h1f, 2'(w), 1'b1, 1'b0);
      lk(1'b1, 5'h1f, 2'(w + 1), 1'b1, w < 3);
    end
    u_ccm_dp_model.fill(5'h03, 2'h1);
    wr(OFF_FLUSH, 32'h0);
    lk(1'b0, 5'h03, 2'h1, 1'b1, 1'b1);
    wr(OFF_FLUSH, 32'h1);
    chk("busy", 32'h1, 32'(busy));
    lk(1'b0, 5'h03, 2'h1, 1'b1, 1'b0);
    for (int n = 0; n < 100 && busy; n++) @(posedge core_clk);
    lk(1'b0, 5'h03, 2'h1, 1'b1, 1'b0);
    u_ccm_dp_model.fill(5'h07, 2'h0);
    wr(OFF_MONGATE, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(OFF_MONSEL, 32'(m));
      wr(OFF_MONCMD, 32'h1);
      rd(OFF_MONCOUNT);
      chk("cleared", 32'h0, rdv);
      lk(1'b0, 5'h07, 2'h0, 1'b1, 1'b1);
      lk(1'b0, 5'h07, 2'h0, 1'b1, 1'b1);
      lk(1'b1, 5'h07, 2'h0, 1'b1, 1'b1);
      lk(1'b0, 5'h07, 2'h0, 1'b0, 1'b0);
      rd(OFF_MONCOUNT);
      chk("tally", 32'((m == 1) ? 2 : (m == 2) ? 1 : 0), rdv);
    end
    wr(OFF_MONSEL, 32'h0);
    rd(OFF_MONCOUNT);
    prev = rdv;
    rd(OFF_MONCOUNT);
    chk("cycles", prev + 32'h2, rdv);
    wr(OFF_MONGATE, 32'h0);
    rd(OFF_MONCOUNT);
    prev = rdv;
    rd(OFF_MONCOUNT);
    chk("held", prev, rdv);
    final_report();
  end
endmodule
